// file: verilog/utch_harness.sv
`timescale 1ns/1ps
`include "utch_params.svh"
// Function
// - With the infrared receive-test bit set, receive stays on while IR sends.
// - With it clear (default) receive is blocked while IR transmits.
// - With FIFO test set, a test data write pushes into the receive FIFO.
// - With FIFO test set, a test data read pops from the transmit FIFO.
// - With FIFO test clear, no test path to either FIFO exists.
// - Integration test enable selects integration mode when set.
// - Input bit 7 stores the tx DMA clear value and reads the mux output.
// - Input bit 6 stores the rx DMA clear value and reads the mux output.
// - Input bits 5..0 read the live primary input pins.
// - Reserved upper bits of both registers read unpredictable (zero here).
// - The input register is read/write, setting and reading block inputs.
// - Mux picks pins in normal mode, stored bits in integration mode.
// - Test data carries 11 bits of data in bits 10..0, rest reserved.
module utch_harness
  import utch_pkg::*;
#(
  parameter int DATA_W = 11
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Register port
  input wire logic i_sel,
  input wire logic i_write,
  input wire logic i_enable,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  // FIFO side of the functional UART
  input wire logic [DATA_W-1:0] i_tx_fifo_data,
  input wire logic i_tx_fifo_empty,
  output logic o_tx_fifo_pop,
  output logic o_rx_fifo_push,
  output logic [DATA_W-1:0] o_rx_fifo_data,
  // Infrared transmitter state and receive gate
  input wire logic i_ir_tx_active,
  output logic o_rx_path_enable,
  // Primary inputs
  input wire logic i_ring_indicator_n,
  input wire logic i_carrier_detect_n,
  input wire logic i_clear_to_send_n,
  input wire logic i_data_set_ready_n,
  input wire logic i_infrared_rx_in,
  input wire logic i_serial_rx_data,
  // Intra-chip DMA clear inputs
  input wire logic i_tx_dma_clear,
  input wire logic i_rx_dma_clear,
  output logic o_tx_dma_clear,
  output logic o_rx_dma_clear,
  output logic o_integration_test_enable
);

  // Everything the block remembers, registered as one record
  typedef struct packed {
    logic [2:0] test_control;
    logic [1:0] integration_input_readset;
    logic [31:0] rdata;
    logic tx_pop;
    logic rx_push;
    logic [DATA_W-1:0] rx_data;
    logic rx_path_enable;
    logic tx_dma_clear;
    logic rx_dma_clear;
  } utch_state_type;

  // Register hit for one decoded target; shared by every strobe
  function automatic logic reg_hit(
    input utch_sel_type decoded,
    input utch_sel_type target
  );
    return decoded == target;
  endfunction

  // Test multiplexer of one intra-chip input line
  function automatic logic dma_clear_mux(
    input logic test_mode,
    input logic stored,
    input logic pin
  );
    return test_mode ? stored : pin;
  endfunction

  // Registered state and address decode
  utch_state_type state;
  utch_state_type next_state;
  utch_sel_type sel;

  // Control fields and access qualifiers
  logic access;
  logic wr_access;
  logic rd_access;
  logic integ_mode;
  logic fifo_test;
  logic ir_rx_test;

  // Per-register strobes and the input read view
  logic wr_test_control;
  logic wr_input_readset;
  logic wr_test_data;
  logic rd_test_control;
  logic rd_input_readset;
  logic rd_test_data;
  logic [7:0] input_word;

  utch_addr_decode u_decode (
    .i_addr(i_addr),
    .o_sel(sel)
  );

  // Control fields as seen by the datapath
  assign integ_mode = state.test_control[`UTCH_BIT_INTEG_TEST_EN];
  assign fifo_test = state.test_control[`UTCH_BIT_FIFO_TEST];
  assign ir_rx_test = state.test_control[`UTCH_BIT_IR_RX_TEST];

  // One access per transfer: act on the enable phase only
  assign access = i_sel & i_enable;
  assign wr_access = access & i_write;
  assign rd_access = access & ~i_write;

  // Per-register strobes; unmapped offsets match none of them
  assign wr_test_control = wr_access &
    reg_hit(sel, utch_sel_test_control);
  assign wr_input_readset = wr_access &
    reg_hit(sel, utch_sel_input_readset);
  assign wr_test_data = wr_access & reg_hit(sel, utch_sel_test_data);
  assign rd_test_control = rd_access &
    reg_hit(sel, utch_sel_test_control);
  assign rd_input_readset = rd_access &
    reg_hit(sel, utch_sel_input_readset);
  assign rd_test_data = rd_access & reg_hit(sel, utch_sel_test_data);

  // Read view of the input register: registered mux outputs on top,
  // live pins below, so a read shows what the core really receives
  assign input_word = {
    state.tx_dma_clear,
    state.rx_dma_clear,
    i_ring_indicator_n,
    i_carrier_detect_n,
    i_clear_to_send_n,
    i_data_set_ready_n,
    i_infrared_rx_in,
    i_serial_rx_data
  };

  // Next-state logic
  always_comb begin
    next_state = state;
    // Strobes and read data last one cycle only
    next_state.tx_pop = 1'b0;
    next_state.rx_push = 1'b0;
    next_state.rdata = 32'h0000_0000; // Reserved bits read zero

    // Internal DMA clear lines
    next_state.tx_dma_clear = dma_clear_mux(integ_mode,
      state.integration_input_readset[1], i_tx_dma_clear);
    next_state.rx_dma_clear = dma_clear_mux(integ_mode,
      state.integration_input_readset[0], i_rx_dma_clear);

    // Receive gated while IR sends unless full duplex test is on
    next_state.rx_path_enable =
      ir_rx_test | ~i_ir_tx_active;

    // Register writes
    if (wr_test_control) begin
      next_state.test_control = i_wdata[2:0];
    end

    if (wr_input_readset) begin
      // Stored values only reach the core in test mode
      next_state.integration_input_readset =
        i_wdata[`UTCH_BIT_TX_DMA_CLR:`UTCH_BIT_RX_DMA_CLR];
    end

    // Test data writes are dropped unless FIFO test is on
    if (wr_test_data && fifo_test) begin
      next_state.rx_push = 1'b1;
      next_state.rx_data = i_wdata[DATA_W-1:0];
    end

    // Register reads; anything not decoded returns zero
    if (rd_test_control) begin
      next_state.rdata[2:0] = state.test_control;
    end

    if (rd_input_readset) begin
      next_state.rdata[7:0] = input_word;
    end

    // Pop only a real entry; an empty FIFO still shows its head
    if (rd_test_data && fifo_test) begin
      next_state.rdata[DATA_W-1:0] = i_tx_fifo_data;
      next_state.tx_pop = ~i_tx_fifo_empty;
    end

    // Synchronous reset overrides everything above
    if (i_srst) begin
      next_state = '0;
      next_state.test_control = `UTCH_RST_TEST_CONTROL;
      next_state.integration_input_readset = `UTCH_RST_INPUT_READSET;
      // Gate open at reset: IR idle, half duplex default
      next_state.rx_path_enable = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    state <= next_state;
  end

  // Outputs straight from flops
  assign o_rdata = state.rdata;
  assign o_tx_fifo_pop = state.tx_pop;
  assign o_rx_fifo_push = state.rx_push;
  assign o_rx_fifo_data = state.rx_data;
  assign o_rx_path_enable = state.rx_path_enable;
  assign o_tx_dma_clear = state.tx_dma_clear;
  assign o_rx_dma_clear = state.rx_dma_clear;
  assign o_integration_test_enable = integ_mode;

endmodule // utch_harness

// file: shared/utch_params.svh
`ifndef UTCH_PARAMS_SVH
`define UTCH_PARAMS_SVH
// Register byte offsets
`define UTCH_OFS_TEST_CONTROL 12'h080
`define UTCH_OFS_INPUT_READSET 12'h084
`define UTCH_OFS_TEST_DATA 12'h08C
// Test control fields
`define UTCH_BIT_INTEG_TEST_EN 0
`define UTCH_BIT_FIFO_TEST 1
`define UTCH_BIT_IR_RX_TEST 2
// Input read/set fields
`define UTCH_BIT_RX_DMA_CLR 6
`define UTCH_BIT_TX_DMA_CLR 7
// Reset values
`define UTCH_RST_TEST_CONTROL 3'h0
`define UTCH_RST_INPUT_READSET 2'h0
`endif

// file: shared/utch_pkg.sv
package utch_pkg;
  // Register selected by a bus access
  typedef enum logic [1:0] {
    utch_sel_none,
    utch_sel_test_control,
    utch_sel_input_readset,
    utch_sel_test_data
  } utch_sel_type;
endpackage

// file: verilog/utch_addr_decode.sv
`timescale 1ns/1ps
`include "utch_params.svh"
module utch_addr_decode
  import utch_pkg::*;
(
  input wire logic [11:0] i_addr,
  output utch_sel_type o_sel
);
  // Full offset compare, unmapped gives none
  always_comb begin
    unique case (i_addr)
      `UTCH_OFS_TEST_CONTROL: o_sel = utch_sel_test_control;
      `UTCH_OFS_INPUT_READSET: o_sel = utch_sel_input_readset;
      `UTCH_OFS_TEST_DATA: o_sel = utch_sel_test_data;
      default: o_sel = utch_sel_none;
    endcase
  end
endmodule // utch_addr_decode

// file: tb/utch_fifo_model.sv
`timescale 1ns/1ps
// Two-entry transmit FIFO; the head steps on each pop
module utch_fifo_model (
  input logic i_core_clk,
  input logic i_pop,
  output logic [10:0] o_data,
  output logic o_empty);
  logic [1:0] n = 2'h0;
  assign o_data = 11'h500 + 11'(n); // Head holds its value until the next pop
  assign o_empty = n[1];
  always_ff @(posedge i_core_clk) if (i_pop) n <= n + 2'h1;
endmodule // utch_fifo_model

// file: tb/utch_harness_props.sv
`timescale 1ns/1ps
module utch_harness_props #(parameter int DATA_W = 11) (
  input logic i_core_clk, i_srst, i_sel, i_write, i_enable,
  input logic [11:0] i_addr,
  input logic [31:0] i_wdata, o_rdata,
  input logic [DATA_W-1:0] i_tx_fifo_data, o_rx_fifo_data,
  input logic i_tx_fifo_empty, o_tx_fifo_pop, o_rx_fifo_push,
  input logic i_ir_tx_active, o_rx_path_enable, i_tx_dma_clear,
  input logic i_rx_dma_clear, o_tx_dma_clear, o_rx_dma_clear);
  logic [2:0] tc;
  logic [1:0] st;
  logic wr, rd, td;
  // Shadow copies of control and stored clear bits
  assign wr = i_sel & i_enable & i_write;
  assign rd = i_sel & i_enable & ~i_write;
  assign td = i_addr == 12'h08C && tc[1];
  always_ff @(posedge i_core_clk) begin
    if (i_srst) tc <= 3'h0;
    else if (wr && i_addr == 12'h080) tc <= i_wdata[2:0];
    if (i_srst) st <= 2'h0;
    else if (wr && i_addr == 12'h084) st <= i_wdata[7:6];
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  property p_psh; wr && td |=> o_rx_fifo_push &&
    o_rx_fifo_data == $past(i_wdata[DATA_W-1:0]); endproperty
  a_psh: assert property (p_psh) else $error("push");
  property p_pop; rd && td && !i_tx_fifo_empty |=> o_tx_fifo_pop &&
    o_rdata[DATA_W-1:0] == $past(i_tx_fifo_data); endproperty
  a_pop: assert property (p_pop) else $error("pop");
  property p_qt; !td |=> !o_rx_fifo_push && !o_tx_fifo_pop; endproperty
  a_qt: assert property (p_qt) else $error("stray");
  property p_rx; 1 |=> o_rx_path_enable ==
    ($past(tc[2]) || !$past(i_ir_tx_active)); endproperty
  a_rx: assert property (p_rx) else $error("rx gate");
  property p_pin; !tc[0] |=> o_tx_dma_clear == $past(i_tx_dma_clear) &&
    o_rx_dma_clear == $past(i_rx_dma_clear); endproperty
  a_pin: assert property (p_pin) else $error("pins");
  property p_set; tc[0] |=> {o_tx_dma_clear, o_rx_dma_clear} == $past(st);
    endproperty
  a_set: assert property (p_set) else $error("set");
  property p_ctl; rd && i_addr == 12'h080 |=>
    o_rdata == {29'h0, $past(tc)}; endproperty
  a_ctl: assert property (p_ctl) else $error("ctl");
  property p_idl; !(i_sel && i_enable) |=> o_rdata == 32'h0; endproperty
  a_idl: assert property (p_idl) else $error("idle");
  c_psh: cover property (wr && td);
  c_pop: cover property (rd && td);
  c_set: cover property (tc[0] && st != 2'h0);
endmodule // utch_harness_props
bind utch_harness utch_harness_props #(.DATA_W(DATA_W)) u_props (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_sel(i_sel),
  .i_write(i_write), .i_enable(i_enable), .i_addr(i_addr),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .i_tx_fifo_data(i_tx_fifo_data),
  .o_rx_fifo_data(o_rx_fifo_data), .i_tx_fifo_empty(i_tx_fifo_empty),
  .o_tx_fifo_pop(o_tx_fifo_pop), .o_rx_fifo_push(o_rx_fifo_push),
  .i_ir_tx_active(i_ir_tx_active), .o_rx_path_enable(o_rx_path_enable),
  .i_tx_dma_clear(i_tx_dma_clear), .i_rx_dma_clear(i_rx_dma_clear),
  .o_tx_dma_clear(o_tx_dma_clear), .o_rx_dma_clear(o_rx_dma_clear));

// file: tb/utch_harness_test.sv
`timescale 1ns/1ps
module utch_harness_test;
  logic i_core_clk = 0, i_srst = 1, i_sel = 0, i_write = 0, i_enable = 0;
  logic i_ir_tx_active = 0, i_tx_dma_clear = 0, i_rx_dma_clear = 0;
  logic i_ring_indicator_n = 0, i_carrier_detect_n = 0;
  logic i_clear_to_send_n = 0, i_data_set_ready_n = 0;
  logic i_infrared_rx_in = 0, i_serial_rx_data = 0, i_tx_fifo_empty;
  logic [11:0] i_addr = 0;
  logic [31:0] i_wdata = 0, o_rdata;
  logic [10:0] i_tx_fifo_data, o_rx_fifo_data;
  logic o_tx_fifo_pop, o_rx_fifo_push, o_rx_path_enable, o_tx_dma_clear;
  logic o_rx_dma_clear, o_integration_test_enable;
  int n_errors = 0, n_tests = 0;
  utch_fifo_model u_fifo (.i_core_clk, .i_pop(o_tx_fifo_pop),
    .o_data(i_tx_fifo_data), .o_empty(i_tx_fifo_empty));
  utch_harness DUT (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_sel(i_sel), .i_write(i_write), .i_enable(i_enable),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_tx_fifo_data(i_tx_fifo_data), .i_tx_fifo_empty(i_tx_fifo_empty),
    .o_tx_fifo_pop(o_tx_fifo_pop), .o_rx_fifo_push(o_rx_fifo_push),
    .o_rx_fifo_data(o_rx_fifo_data), .i_ir_tx_active(i_ir_tx_active),
    .o_rx_path_enable(o_rx_path_enable),
    .i_ring_indicator_n(i_ring_indicator_n),
    .i_carrier_detect_n(i_carrier_detect_n),
    .i_clear_to_send_n(i_clear_to_send_n),
    .i_data_set_ready_n(i_data_set_ready_n),
    .i_infrared_rx_in(i_infrared_rx_in),
    .i_serial_rx_data(i_serial_rx_data),
    .i_tx_dma_clear(i_tx_dma_clear), .i_rx_dma_clear(i_rx_dma_clear),
    .o_tx_dma_clear(o_tx_dma_clear), .o_rx_dma_clear(o_rx_dma_clear),
    .o_integration_test_enable(o_integration_test_enable));
  task chk(input logic [32:0] g, e);
    n_tests++;
    if (g !== e) n_errors++;
    if (g !== e) $display("unexpected at %0t: %h %h", $time, g, e);
  endtask
  // One-cycle strobes; results sampled once the answer edge settles
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    {i_sel, i_enable, i_write, i_addr, i_wdata} <= {2'h3, w, a, d};
    @(posedge i_core_clk);
    {i_sel, i_enable} <= 2'h0;
    #1;
  endtask
  task t_fifo;
    acc(1'h1, 12'h08C, 32'h1);
    chk({o_rx_fifo_push, o_tx_fifo_pop}, 0);
    acc(1'h1, 12'h080, 32'hFFFF_FFFA);
    acc(1'h1, 12'h08C, 32'hFFFF_FAA5);
    chk({o_rx_fifo_push, o_rx_fifo_data}, 12'hAA5);
    for (int k = 0; k < 3; k++) begin
      acc(1'h0, 12'h08C, 32'h0);
      chk({o_tx_fifo_pop, o_rdata}, {k < 2, 32'h500 + k});
    end
    $display("fifo test done");
  endtask
  task t_in;
    @(posedge i_core_clk);
    {i_tx_dma_clear, i_ring_indicator_n, i_clear_to_send_n} <= 3'h7;
    acc(1'h0, 12'h084, 32'h0);
    chk(o_rdata, 32'h0000_00A8);
    chk({o_integration_test_enable, o_tx_dma_clear, o_rx_dma_clear}, 2);
    acc(1'h1, 12'h080, 32'h1);
    acc(1'h1, 12'h084, 32'hFFFF_FF40);
    acc(1'h0, 12'h084, 32'h0);
    chk(o_rdata, 32'h0000_0068);
    chk({o_integration_test_enable, o_tx_dma_clear, o_rx_dma_clear}, 5);
    @(posedge i_core_clk);
    i_ir_tx_active <= 1'h1;
    acc(1'h0, 12'h090, 32'h0);
    chk({o_rx_path_enable, o_rdata}, 0);
    acc(1'h1, 12'h080, 32'h4);
    // Gate is registered: the new control bit shows one edge later
    @(posedge i_core_clk);
    #1;
    chk(o_rx_path_enable, 1);
    acc(1'h0, 12'h080, 32'h0);
    chk({o_integration_test_enable, o_rdata}, 32'h4);
    $display("input test done");
  endtask
  task end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #4 i_core_clk = ~i_core_clk;
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_srst <= 1'h0;
    t_fifo;
    t_in;
    end_sim;
  end
  // Watchdog, far beyond the thirteen accesses above
  initial begin
    #8000;
    n_errors++;
    end_sim;
  end
endmodule // utch_harness_test
